// *** dpra_pkg.sv ***
// package: constants, codes and carriers of the training-pattern access block
package dpra_pkg;

  // ----------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------
  localparam logic [7:0] APB_CTRL_OFF = 8'h00;
  localparam logic [7:0] APB_STATUS_OFF = 8'h04;
  localparam logic [7:0] APB_PATTERN_OFF = 8'h08;
  localparam logic [7:0] APB_ERRCNT_OFF = 8'h0C;
  localparam int CTRL_CAS_LSB = 0;
  localparam logic [4:0] CTRL_CAS_RST = 5'h0A;
  localparam int STAT_EN_BIT = 0;
  localparam int STAT_PAGE_LSB = 1;
  localparam int STAT_FMT_LSB = 3;
  localparam int STAT_BL_LSB = 5;
  localparam int STAT_PL_LSB = 7;
  localparam int STAT_BUSY_BIT = 10;

  // ----------------------------------------------------------------
  // mode-register selection and field positions
  // ----------------------------------------------------------------
  localparam logic [1:0] MR_LATBURST_BA = 2'h0;
  localparam logic [1:0] MR_LATBURST_BG = 2'h0;
  localparam logic [1:0] MR_TRAIN_BA = 2'h3;
  localparam logic [1:0] MR_TRAIN_BG = 2'h0;
  localparam logic [1:0] MR_PARITY_BA = 2'h1;
  localparam logic [1:0] MR_PARITY_BG = 2'h1;
  localparam int TRN_EN_BIT = 2;
  localparam int TRN_PAGE_LSB = 0;
  localparam int TRN_FMT_LSB = 11;
  localparam int BL_LSB = 0;
  localparam int PL_LSB = 0;
  localparam int CHOP_BIT = 12;
  localparam int HALF_BIT = 2;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_CHOP4 = 2'h2;
  localparam logic [1:0] PAGE_PATTERN = 2'h0;

  // ----------------------------------------------------------------
  // default patterns restored on re-initialisation
  // ----------------------------------------------------------------
  localparam logic [7:0] PAT0_RST = 8'h55;
  localparam logic [7:0] PAT1_RST = 8'h33;
  localparam logic [7:0] PAT2_RST = 8'h0F;
  localparam logic [7:0] PAT3_RST = 8'h00;

  // ----------------------------------------------------------------
  // timing: last unit interval of a burst and beats per chopped burst
  // ----------------------------------------------------------------
  localparam logic [2:0] UI_LAST = 3'h7;
  localparam logic [2:0] CHOP_BEATS = 3'h4;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FMT_SERIAL = 2'h0,
    FMT_PARALLEL = 2'h1,
    FMT_STAGGER = 2'h2,
    FMT_RSVD = 2'h3
  } dpra_fmt_t;

  // command pins from the controller
  typedef struct packed {
    logic cs_n;
    logic act_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bg;
    logic [1:0] ba;
    logic [17:0] addr;
  } dpra_cmd_t;

  // one pending pattern read
  typedef struct packed {
    logic valid;
    logic chop;
    logic half;
    logic [1:0] loc;
  } dpra_rd_t;

endpackage : dpra_pkg

// *** dpra_pattern_store.sv ***
// file: four 8-bit training pattern locations with default values
`timescale 1ns/1ns
module dpra_pattern_store
  import dpra_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic reinit,
  input wire logic wr_en,
  input wire logic [1:0] wr_loc,
  input wire logic [7:0] wr_data,
  // contents, straight from flip-flops
  output logic [3:0][7:0] pat_q
);

  logic [3:0][7:0] pat_reg;
  logic [3:0][7:0] pat_next;
  localparam logic [3:0][7:0] PAT_DEFAULT = {PAT3_RST, PAT2_RST, PAT1_RST, PAT0_RST};

  // defaults return only on re-initialisation, never on mode exit
  always_comb begin
    pat_next = pat_reg;
    if (reinit) begin
      pat_next = PAT_DEFAULT; // RL18
    end else if (wr_en) begin
      pat_next[wr_loc] = wr_data; // RL15
    end
  end

  // storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pat_reg <= PAT_DEFAULT;
    end else begin
      pat_reg <= pat_next;
    end
  end

  assign pat_q = pat_reg;

endmodule : dpra_pattern_store

// *** dpra_top.sv ***
// file: training-pattern register access logic of the memory device
// What the document requires of this block and of its controller
// RL1: format field picks serial, parallel or staggered
// RL2: serial drives same pattern bits on all lanes
// RL3: parallel uses location 0 byte across lanes
// RL4: parallel byte on both lane bytes, all UIs
// RL5: staggered lane j reads location n plus j
// RL6: staggered location index wraps modulo four
// RL7: upper nibble repeats lower nibble assignment
// RL8: sixteen lanes carry locations 0..3 four times
// RL9: back-to-back reads give gapless bursts
// RL10: controller drives column bits 1:0 and 2 low
// RL11: chopped read gives four beats then undriven
// RL12: chop bit must be one in on-the-fly length
// RL13: bank bits select location, others ignored
// RL14: parity latency adds to read data delay
// RL15: write loads address bits 7:0 into location
// RL16: address bit k appears in UI k
// RL17: controller keeps bus inversion off on writes
// RL18: written values persist until re-initialisation
// RL19: controller locks DLL, precharges before entry
// RL20: controller writes only with page 0 selected
// RL21: controller waits mode delays before access
// RL22: writes in pattern mode go to locations
// RL23: controller waits write recovery after writes
// RL24: controller waits exit delay, then clears enable
// RL25: clearing enable returns commands to array
// RL26: controller uses only single-rate refresh
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ns
module dpra_top
  import dpra_pkg::*;
#(
  parameter int LANES = 16,
  parameter int LAT_MAX = 32
) (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // command link from the controller
  input wire logic link_ck,
  input wire logic link_rst_n,
  input wire dpra_cmd_t cmd_pins,
  // data lanes
  output logic [LANES-1:0] dq_out,
  output logic dq_oe,
  // status and array steering
  output logic mode_active,
  output logic array_rd_pulse,
  output logic array_wr_pulse
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (LANES != 8 && LANES != 16) begin : g_bad_lanes
    $error("LANES must be 8 or 16");
  end
  if (LAT_MAX < 2 || LAT_MAX > 64) begin : g_bad_lat
    $error("LAT_MAX must lie in 2..64");
  end
  localparam int TW = $clog2(LAT_MAX);

  // ----------------------------------------------------------------
  // synchronisers and link edge detection
  // ----------------------------------------------------------------
  logic ck_s1, ck_s2, ck_s3, rst_s1, rst_s2;
  dpra_cmd_t cmd_s1, cmd_s2;
  // two flops on every pin, a third flop only for the clock edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
      cmd_s1 <= '1;
      cmd_s2 <= '1;
    end else begin
      ck_s1 <= link_ck;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      rst_s1 <= link_rst_n;
      rst_s2 <= rst_s1;
      cmd_s1 <= cmd_pins;
      cmd_s2 <= cmd_s1;
    end
  end

  logic ck_rise, ck_fall, reinit, cmd_take;
  logic is_mrs, is_rd, is_wr;
  assign ck_rise = ck_s2 & ~ck_s3;
  assign ck_fall = ~ck_s2 & ck_s3;
  assign reinit = ~rst_s2;
  assign cmd_take = ck_rise & ~cmd_s2.cs_n & ~reinit;
  assign is_mrs = cmd_take & cmd_s2.act_n & ~cmd_s2.ras_n & ~cmd_s2.cas_n & ~cmd_s2.we_n;
  assign is_rd = cmd_take & cmd_s2.act_n & cmd_s2.ras_n & ~cmd_s2.cas_n & cmd_s2.we_n;
  assign is_wr = cmd_take & cmd_s2.act_n & cmd_s2.ras_n & ~cmd_s2.cas_n & ~cmd_s2.we_n;

  // ----------------------------------------------------------------
  // mode registers seen by this block
  // ----------------------------------------------------------------
  logic mode_en_reg, mode_en_next;
  logic [1:0] page_reg, page_next, bl_reg, bl_next;
  dpra_fmt_t fmt_reg, fmt_next;
  logic [2:0] pl_reg, pl_next;
  logic mr_train, mr_latburst, mr_parity;
  assign mr_train = cmd_s2.ba == MR_TRAIN_BA && cmd_s2.bg == MR_TRAIN_BG;
  assign mr_latburst = cmd_s2.ba == MR_LATBURST_BA && cmd_s2.bg == MR_LATBURST_BG;
  assign mr_parity = cmd_s2.ba == MR_PARITY_BA && cmd_s2.bg == MR_PARITY_BG;

  // mode-register writes update enable, page, format, length, parity latency
  always_comb begin
    mode_en_next = mode_en_reg;
    page_next = page_reg;
    fmt_next = fmt_reg;
    bl_next = bl_reg;
    pl_next = pl_reg;
    if (reinit) begin
      mode_en_next = 1'b0;
      page_next = PAGE_PATTERN;
      fmt_next = FMT_SERIAL;
      bl_next = BL_FIXED8;
      pl_next = 3'h0;
    end else if (is_mrs && mr_train) begin
      mode_en_next = cmd_s2.addr[TRN_EN_BIT]; // RL25
      page_next = cmd_s2.addr[TRN_PAGE_LSB +: 2];
      fmt_next = dpra_fmt_t'(cmd_s2.addr[TRN_FMT_LSB +: 2]); // RL1
    end else if (is_mrs && mr_latburst) begin
      bl_next = cmd_s2.addr[BL_LSB +: 2];
    end else if (is_mrs && mr_parity) begin
      pl_next = cmd_s2.addr[PL_LSB +: 3];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_en_reg <= 1'b0;
      page_reg <= PAGE_PATTERN;
      fmt_reg <= FMT_SERIAL;
      bl_reg <= BL_FIXED8;
      pl_reg <= 3'h0;
    end else begin
      mode_en_reg <= mode_en_next;
      page_reg <= page_next;
      fmt_reg <= fmt_next;
      bl_reg <= bl_next;
      pl_reg <= pl_next;
    end
  end

  // ----------------------------------------------------------------
  // pattern store and redirection of commands
  // ----------------------------------------------------------------
  logic [3:0][7:0] pat_q;
  logic pat_wr;
  // bank bits pick the location; other address bits are ignored
  assign pat_wr = is_wr & mode_en_reg & page_reg == PAGE_PATTERN; // RL22 RL13

  dpra_pattern_store u_store (
    .pclk(pclk),
    .presetn(presetn),
    .reinit(reinit),
    .wr_en(pat_wr),
    .wr_loc(cmd_s2.ba),
    .wr_data(cmd_s2.addr[7:0]),
    .pat_q(pat_q)
  );

  logic arr_rd_reg, arr_rd_next, arr_wr_reg, arr_wr_next;
  // outside pattern mode, reads and writes go to the array
  always_comb begin
    arr_rd_next = is_rd & ~mode_en_reg; // RL25
    arr_wr_next = is_wr & ~mode_en_reg; // RL22
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arr_rd_reg <= 1'b0;
      arr_wr_reg <= 1'b0;
    end else begin
      arr_rd_reg <= arr_rd_next;
      arr_wr_reg <= arr_wr_next;
    end
  end

  // ----------------------------------------------------------------
  // read latency line, advanced on each link rising edge
  // ----------------------------------------------------------------
  logic [4:0] cas_reg, cas_next;
  dpra_rd_t [LAT_MAX-1:0] dline_reg, dline_next;
  dpra_rd_t rd_new, tap;
  logic [5:0] lat_sum;
  logic [TW-1:0] tap_idx;
  assign lat_sum = {1'b0, cas_reg} + {3'h0, pl_reg}; // RL14
  // latency clamped into the line; zero acts as one
  assign tap_idx = (lat_sum == 6'h00) ? '0 :
                   (32'(lat_sum) > LAT_MAX) ? TW'(LAT_MAX - 1) : TW'(lat_sum - 6'h01);
  assign tap = dline_reg[tap_idx];

  // chop when the fixed chopped length is programmed
  always_comb begin
    rd_new.valid = is_rd & mode_en_reg;
    rd_new.chop = bl_reg == BL_CHOP4; // RL11 RL12
    rd_new.half = cmd_s2.addr[HALF_BIT] & (bl_reg == BL_CHOP4);
    rd_new.loc = cmd_s2.ba; // RL13
    dline_next = dline_reg;
    if (ck_rise) begin
      dline_next = {dline_reg[LAT_MAX-2:0], rd_new};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dline_reg <= '0;
    end else begin
      dline_reg <= dline_next;
    end
  end

  // ----------------------------------------------------------------
  // burst output, one unit interval per link clock edge
  // ----------------------------------------------------------------
  logic act_reg, act_next, oe_reg, oe_next;
  logic [2:0] ui_reg, ui_next;
  dpra_rd_t cur_reg, cur_next;
  logic [LANES-1:0] dq_reg, dq_next, lane_bit;
  logic start, ui_edge, beat_on;
  logic [2:0] beat;
  assign start = ck_rise & tap.valid;
  assign ui_edge = ck_rise | ck_fall;

  // the unit interval that the coming edge presents
  always_comb begin
    act_next = act_reg;
    ui_next = ui_reg;
    cur_next = cur_reg;
    if (start) begin
      act_next = 1'b1; // RL9
      ui_next = 3'h0;
      cur_next = tap;
    end else if (ui_edge && act_reg) begin
      act_next = ui_reg != UI_LAST;
      ui_next = ui_reg + 3'h1;
    end
  end

  // beat number and whether the lanes are driven in it
  always_comb begin
    beat = cur_next.half ? ui_next + CHOP_BEATS : ui_next;
    beat_on = act_next & ~(cur_next.chop & ui_next >= CHOP_BEATS); // RL11
  end

  // per-lane data source chosen by the read format
  for (genvar j = 0; j < LANES; j++) begin : g_lane
    logic [1:0] sloc;
    assign sloc = 2'(cur_next.loc + 2'(j % 4)); // RL6 RL7 RL8
    always_comb begin
      unique case (fmt_reg)
        FMT_SERIAL: lane_bit[j] = page_reg == PAGE_PATTERN && pat_q[cur_next.loc][beat]; // RL2 RL16
        FMT_PARALLEL: lane_bit[j] = pat_q[0][j % 8]; // RL3 RL4
        FMT_STAGGER: lane_bit[j] = pat_q[sloc][beat]; // RL5
        default: lane_bit[j] = 1'b0;
      endcase
    end
  end

  always_comb begin
    oe_next = oe_reg;
    dq_next = dq_reg;
    if (start || ui_edge) begin
      oe_next = beat_on;
      dq_next = beat_on ? lane_bit : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_reg <= 1'b0;
      ui_reg <= 3'h0;
      cur_reg <= '0;
      oe_reg <= 1'b0;
      dq_reg <= '0;
    end else begin
      act_reg <= act_next;
      ui_reg <= ui_next;
      cur_reg <= cur_next;
      oe_reg <= oe_next;
      dq_reg <= dq_next;
    end
  end

  // ----------------------------------------------------------------
  // misuse counter and apb slave
  // ----------------------------------------------------------------
  logic [7:0] err_reg, err_next;
  logic misuse;
  // parallel read off location 0, reserved format, on-the-fly read with chop bit low, write off page 0
  assign misuse = (is_rd & mode_en_reg & ((fmt_reg == FMT_PARALLEL & cmd_s2.ba != 2'h0) |
                  fmt_reg == FMT_RSVD | (bl_reg == BL_OTF & ~cmd_s2.addr[CHOP_BIT]))) |
                  (is_wr & mode_en_reg & page_reg != PAGE_PATTERN);

  logic setup, access, hit;
  logic [31:0] rd_mux, prdata_reg, prdata_next;
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign hit = paddr == APB_CTRL_OFF || paddr == APB_STATUS_OFF ||
               paddr == APB_PATTERN_OFF || paddr == APB_ERRCNT_OFF;

  // read mux for the word captured in the setup cycle
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      APB_CTRL_OFF: rd_mux[CTRL_CAS_LSB +: 5] = cas_reg;
      APB_STATUS_OFF: begin
        rd_mux[STAT_EN_BIT] = mode_en_reg;
        rd_mux[STAT_PAGE_LSB +: 2] = page_reg;
        rd_mux[STAT_FMT_LSB +: 2] = fmt_reg;
        rd_mux[STAT_BL_LSB +: 2] = bl_reg;
        rd_mux[STAT_PL_LSB +: 3] = pl_reg;
        rd_mux[STAT_BUSY_BIT] = act_reg;
      end
      APB_PATTERN_OFF: rd_mux = pat_q;
      APB_ERRCNT_OFF: rd_mux[7:0] = err_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    cas_next = cas_reg;
    err_next = err_reg;
    prdata_next = setup ? rd_mux : prdata_reg;
    if (access && pwrite && paddr == APB_CTRL_OFF) begin
      cas_next = pwdata[CTRL_CAS_LSB +: 5];
    end
    if (misuse && err_reg != 8'hFF) begin
      err_next = err_reg + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cas_reg <= CTRL_CAS_RST;
      err_reg <= 8'h00;
      prdata_reg <= 32'h0000_0000;
    end else begin
      cas_reg <= cas_next;
      err_reg <= err_next;
      prdata_reg <= prdata_next;
    end
  end

  // outputs
  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = access & ~hit;
  assign dq_out = dq_reg;
  assign dq_oe = oe_reg;
  assign mode_active = mode_en_reg;
  assign array_rd_pulse = arr_rd_reg;
  assign array_wr_pulse = arr_wr_reg;

  // ----------------------------------------------------------------
  // assertions and covers
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_serial_lanes_same: assert property (dq_oe && fmt_reg == FMT_SERIAL |-> dq_out == {LANES{dq_out[0]}}) // RL2
    else $error("serial lanes differ");
  a_parallel_bytes: assert property (dq_oe && fmt_reg == FMT_PARALLEL |-> // RL4
    dq_out == {(LANES / 8){pat_q[0]}})
    else $error("parallel byte wrong");
  a_stagger_repeat: assert property (dq_oe && fmt_reg == FMT_STAGGER |-> dq_out[LANES-1:4] == dq_out[LANES-5:0]) // RL8
    else $error("stagger nibbles differ");
  a_chop_undriven: assert property (act_reg && cur_reg.chop && ui_reg >= CHOP_BEATS && !start |-> !dq_oe) // RL11
    else $error("chopped beat driven");
  a_no_array_in_mode: assert property (is_wr && mode_en_reg |=> !array_wr_pulse) // RL22
    else $error("write leaked to array");
  a_exit_redirect: assert property (is_rd && !mode_en_reg |=> array_rd_pulse) // RL25
    else $error("read not returned to array");
  a_write_loads: assert property (pat_wr |=> pat_q[$past(cmd_s2.ba)] == $past(cmd_s2.addr[7:0])) // RL15
    else $error("pattern write lost");
  a_reinit_default: assert property (reinit |=> pat_q[0] == PAT0_RST && pat_q[3] == PAT3_RST && !mode_en_reg) // RL18
    else $error("defaults not restored");
  a_burst_length: assert property ($fell(act_reg) |-> $past(ui_reg) == UI_LAST) // RL9
    else $error("burst cut short");
  a_unmapped_err: assert property (psel && penable && !hit |-> pslverr && pready)
    else $error("unmapped access not refused");

  c_serial: cover property (dq_oe && fmt_reg == FMT_SERIAL);
  c_parallel: cover property (dq_oe && fmt_reg == FMT_PARALLEL);
  c_stagger: cover property (dq_oe && fmt_reg == FMT_STAGGER);
  c_back_to_back: cover property (start && act_reg && ui_reg == UI_LAST);

endmodule : dpra_top

// *** dpra_ctrl_model.sv ***
// file: controller model that drives the command link
`timescale 1ns/1ns
module dpra_ctrl_model
  import dpra_pkg::*;
(
  // link to the device
  output logic link_ck,
  output dpra_cmd_t cmd_pins
);
  realtime t_cmd;

  // free-running link clock, offset in phase from the system clock
  initial begin
    link_ck = 1'b0;
    cmd_pins = '1;
    t_cmd = 0;
    #3;
    forever #80 link_ck = ~link_ck;
  end

  // one command held a full link period, next one gap link clocks later
  // the model has no inversion pin, so inversion is never on
  task automatic send(input logic [2:0] rcw, input logic [3:0] bgba, input logic [17:0] a,
                      input int gap);
    @(negedge link_ck);
    cmd_pins <= {1'b0, 1'b1, rcw, bgba, a};
    @(posedge link_ck);
    t_cmd = $realtime;
    @(negedge link_ck);
    cmd_pins <= {1'b1, ~cmd_pins[25:0]}; // deselected lines show no stale value
    repeat (gap - 2) @(negedge link_ck);
  endtask : send
endmodule : dpra_ctrl_model

// *** dpra_top_test.sv ***
// file: self-checking bench of the training-pattern access block
`timescale 1ns/1ns
module dpra_top_test
  import dpra_pkg::*;
;
  localparam int T_MOD = 24;
  localparam int T_WR = 8;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, link_rst_n, link_ck, err;
  logic pready, pslverr, dq_oe, mode_active, array_rd_pulse, array_wr_pulse;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_word;
  logic [15:0] dq_out;
  logic [15:0] ui [0:31];
  logic oe_s [0:31];
  logic [7:0] pat [0:3];
  dpra_cmd_t cmd_pins;
  realtime lat, l0;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  int arr_rd = 0;
  int arr_wr = 0;

  // ----------------------------------------------------------------
  // design, partner and clocks
  // ----------------------------------------------------------------
  dpra_top #(.LANES(16), .LAT_MAX(32)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_ck(link_ck), .link_rst_n(link_rst_n), .cmd_pins(cmd_pins), .dq_out(dq_out),
    .dq_oe(dq_oe), .mode_active(mode_active), .array_rd_pulse(array_rd_pulse),
    .array_wr_pulse(array_wr_pulse));
  dpra_ctrl_model m (.link_ck(link_ck), .cmd_pins(cmd_pins));

  always #5 pclk = ~pclk;

  // cut a hang short and count pulses that steer commands to the array
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (array_rd_pulse === 1'b1) arr_rd <= arr_rd + 1;
    if (array_wr_pulse === 1'b1) arr_wr <= arr_wr + 1;
    if (cycles == 30000) begin
      fail_count++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_word = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic mrs(input logic [1:0] bg, input logic [1:0] ba, input logic [17:0] a);
    m.send(3'b000, {bg, ba}, a, T_MOD);
  endtask : mrs

  // page field always 00
  task automatic trn(input logic en, input logic [1:0] fmt);
    mrs(MR_TRAIN_BG, MR_TRAIN_BA, (18'(fmt) << TRN_FMT_LSB) | (18'(en) << TRN_EN_BIT));
  endtask : trn

  // column bits low bank group and bit 10 set but ignored
  task automatic rd(input logic [1:0] n, input int gap);
    m.send(3'b101, {2'h2, n}, 18'h00400, gap);
  endtask : rd

  // sample each unit interval mid-way after the lanes come up
  task automatic grab(input int n);
    int w;
    w = 0;
    while (dq_oe !== 1'b1 && w < 3000) begin
      @(posedge pclk);
      w++;
    end
    lat = $realtime - m.t_cmd;
    repeat (4) @(posedge pclk);
    for (int k = 0; k < n; k++) begin
      ui[k] = dq_out;
      oe_s[k] = dq_oe;
      repeat (8) @(posedge pclk);
    end
  endtask : grab

  task automatic judge(input int f, input int n, input int b, input int c);
    logic [15:0] e;
    for (int k = 0; k < c; k++) begin
      for (int j = 0; j < 16; j++) begin
        e[j] = (f == 0) ? pat[n][k] : (f == 1) ? pat[0][j % 8] : pat[(n + j) % 4][k];
      end
      check("lane data", 32'(ui[b + k]), 32'(e));
      check("lane enable", 32'(oe_s[b + k]), 32'h1);
    end
  endtask : judge

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    apb(1'b0, APB_CTRL_OFF, 32'h0);
    check("cas reset", rd_word, 32'(CTRL_CAS_RST));
    apb(1'b0, APB_STATUS_OFF, 32'h0);
    check("status reset", rd_word, 32'h0);
    apb(1'b0, APB_PATTERN_OFF, 32'h0);
    check("pattern defaults", rd_word, {pat[3], pat[2], pat[1], pat[0]});
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped error", 32'(err), 32'h1);
    check("unmapped data", rd_word, 32'h0);
    apb(1'b1, APB_CTRL_OFF, 32'h8);
    apb(1'b0, APB_CTRL_OFF, 32'h0);
    check("cas written", rd_word, 32'h8);
  endtask : t_reset

  // banks idle since reset before entry
  task automatic t_serial;
    trn(1'b1, FMT_SERIAL);
    check("mode on", 32'(mode_active), 32'h1);
    for (int n = 0; n < 4; n++) begin
      rd(2'(n), 4);
      grab(8);
      judge(0, n, 0, 8);
    end
  endtask : t_serial

  task automatic t_write;
    for (int n = 0; n < 4; n++) begin
      pat[n] = 8'hC3 ^ 8'(n * 37);
      m.send(3'b100, {2'h3, 2'(n)}, {10'h3FF, pat[n]}, T_WR);
    end
    m.send(3'b001, 4'h0, 18'h0, T_WR);
    apb(1'b0, APB_PATTERN_OFF, 32'h0);
    check("pattern written", rd_word, {pat[3], pat[2], pat[1], pat[0]});
    check("array writes", 32'(arr_wr), 32'h0);
    rd(2'h2, 4);
    grab(8);
    judge(0, 2, 0, 8);
  endtask : t_write

  task automatic t_parallel;
    trn(1'b1, FMT_PARALLEL);
    rd(2'h0, 4);
    grab(8);
    judge(1, 0, 0, 8);
    rd(2'h1, 40);
    apb(1'b0, APB_ERRCNT_OFF, 32'h0);
    check("misuse count", rd_word, 32'h1);
  endtask : t_parallel

  task automatic t_stagger;
    trn(1'b1, FMT_STAGGER);
    fork
      for (int n = 0; n < 4; n++) rd(2'(n), 4);
      grab(32);
    join
    for (int n = 0; n < 4; n++) judge(2, n, 8 * n, 8);
  endtask : t_stagger

  task automatic t_chop;
    mrs(MR_LATBURST_BG, MR_LATBURST_BA, 18'(BL_CHOP4));
    trn(1'b1, FMT_SERIAL);
    rd(2'h1, 4);
    grab(8);
    judge(0, 1, 0, 4);
    for (int k = 4; k < 8; k++) check("chop idle", {15'h0, oe_s[k], ui[k]}, 32'h0);
    mrs(MR_LATBURST_BG, MR_LATBURST_BA, 18'(BL_OTF));
    rd(2'h1, 8);
    apb(1'b0, APB_ERRCNT_OFF, 32'h0);
    check("otf misuse", rd_word, 32'h2);
    mrs(MR_LATBURST_BG, MR_LATBURST_BA, 18'(BL_FIXED8));
  endtask : t_chop

  task automatic t_parity;
    rd(2'h0, 4);
    grab(8);
    l0 = lat;
    mrs(MR_PARITY_BG, MR_PARITY_BA, 18'h2);
    apb(1'b0, APB_STATUS_OFF, 32'h0);
    check("status", rd_word, (32'h1 << STAT_EN_BIT) | (32'h2 << STAT_PL_LSB));
    rd(2'h0, 4);
    grab(8);
    check("parity delay", 32'(int'(lat - l0)), 32'd320);
    judge(0, 0, 0, 8);
    mrs(MR_PARITY_BG, MR_PARITY_BA, 18'h0);
  endtask : t_parity

  // exit after the final mode delay
  task automatic t_exit;
    trn(1'b0, FMT_SERIAL);
    check("mode off", 32'(mode_active), 32'h0);
    rd(2'h0, 8);
    m.send(3'b100, 4'h0, 18'h0, 8);
    check("array reads", 32'(arr_rd), 32'h1);
    check("array writes", 32'(arr_wr), 32'h1);
    trn(1'b1, FMT_SERIAL);
    rd(2'h3, 4);
    grab(8);
    judge(0, 3, 0, 8);
    @(posedge pclk);
    link_rst_n <= 1'b0;
    repeat (10) @(posedge pclk);
    link_rst_n <= 1'b1;
    repeat (10) @(posedge pclk);
    pat = '{PAT0_RST, PAT1_RST, PAT2_RST, PAT3_RST};
    apb(1'b0, APB_PATTERN_OFF, 32'h0);
    check("pattern reinit", rd_word, {pat[3], pat[2], pat[1], pat[0]});
    check("mode reinit", 32'(mode_active), 32'h0);
  endtask : t_exit

  // main sequence
  initial begin
    presetn = 1'b0;
    link_rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pat = '{PAT0_RST, PAT1_RST, PAT2_RST, PAT3_RST};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    link_rst_n <= 1'b1;
    repeat (5) @(posedge pclk);
    t_reset();
    t_serial();
    t_write();
    t_parallel();
    t_stagger();
    t_chop();
    t_parity();
    t_exit();
    end_sim();
  end
endmodule : dpra_top_test
